// >>> lpc_consts.vh
`ifndef LPC_CONSTS_VH
`define LPC_CONSTS_VH

// Register addresses on the serial control bus
`define LPC_CTRL_ADDR      8'hc3
`define LPC_STATUS_ADDR    8'hc4

// Control register reset value
`define LPC_CTRL_RESET     8'h00

// Control register bit positions
`define LPC_BIT_ENG_RESET  7
`define LPC_BIT_LIST_OK    5
`define LPC_BIT_KEY_OK     4
`define LPC_BIT_CIPHER_OFF 3
`define LPC_BIT_CIPHER_ON  2
`define LPC_BIT_AUTH_DIS   1
`define LPC_BIT_AUTH_START 0

// Status register bit positions
`define LPC_STS_AUTH_DONE  0
`define LPC_STS_KEY_RDY    1
`define LPC_STS_LIST_RDY   2

// Cipher policy field encoding
`define LPC_POLICY_ALWAYS  2'b10

`endif

// >>> lpc_status.v
`timescale 1ns/1ps
`include "lpc_consts.vh"

module lpc_status (
  input  wire       sys_clk,
  input  wire       rstn,
  input  wire       key_ready_set,
  input  wire       list_ready_set,
  input  wire       auth_pass_set,
  input  wire       auth_lost,
  input  wire       key_approve_pulse,
  input  wire       list_approve_pulse,
  input  wire       restart_pulse,
  input  wire       engine_stop_pulse,
  output reg        auth_done_reg,
  output reg        receiver_key_ready_reg,
  output reg        repeater_key_list_ready_reg
);

  reg auth_done_next;
  reg receiver_key_ready_next;
  reg repeater_key_list_ready_next;

  // Engine events win over clears so none is lost
  always @* begin
    auth_done_next = auth_done_reg;
    if (auth_lost || restart_pulse || engine_stop_pulse) begin
      auth_done_next = 1'b0;
    end
    if (auth_pass_set) begin
      auth_done_next = 1'b1;
    end
    receiver_key_ready_next = receiver_key_ready_reg;
    if (key_approve_pulse || engine_stop_pulse) begin
      receiver_key_ready_next = 1'b0;
    end
    if (key_ready_set) begin
      receiver_key_ready_next = 1'b1;
    end
    repeater_key_list_ready_next = repeater_key_list_ready_reg;
    if (list_approve_pulse || engine_stop_pulse) begin
      repeater_key_list_ready_next = 1'b0;
    end
    if (list_ready_set) begin
      repeater_key_list_ready_next = 1'b1;
    end
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      auth_done_reg               <= 1'b0;
      receiver_key_ready_reg      <= 1'b0;
      repeater_key_list_ready_reg <= 1'b0;
    end else begin
      auth_done_reg               <= auth_done_next;
      receiver_key_ready_reg      <= receiver_key_ready_next;
      repeater_key_list_ready_reg <= repeater_key_list_ready_next;
    end
  end

endmodule // lpc_status

// >>> lpc_ctrl.v
// Overview of operation
// - Bit 7 write resets engine, self-clears
// - List approval lets authentication finish, self-clears
// - Key approval cleared by key-ready; zero ignored
// - Cipher-off pulse sends clear video unless policy is 10, keeps auth
// - Cipher on: encrypted if authenticated, else blue
// - Cipher off: video sent unencrypted
// - Always policy forces cipher-on read as one
// - Bit 1 write disables authentication, self-clears
// - Bit 0 write enables or restarts authentication
// - Start bit reads enable state; zero ignored
// - Policy field value 10 means always encrypt
// - Key-ready flag asserts when receiver key available
// - List-ready flag clears on list approval
// - Auth-done clears on loss or restart
`timescale 1ns/1ps
`include "lpc_consts.vh"

module lpc_ctrl (
  input  wire       sys_clk,
  input  wire       rstn,
  input  wire [7:0] reg_addr,
  input  wire       reg_wr_en,
  input  wire [7:0] reg_wr_data,
  input  wire       reg_rd_en,
  input  wire [1:0] cipher_policy,
  input  wire       key_ready_set,
  input  wire       list_ready_set,
  input  wire       auth_pass_set,
  input  wire       auth_lost,
  output reg  [7:0] reg_rd_data_reg,
  output reg        reg_rd_valid_reg,
  output reg        protect_engine_reset_reg,
  output reg        auth_enable_reg,
  output reg        auth_restart_reg,
  output reg        auth_disable_pulse_reg,
  output reg        receiver_key_approved_reg,
  output reg        repeater_key_list_approved_reg,
  output reg        cipher_off_pulse_reg,
  output reg        encrypt_video_reg,
  output reg        blue_screen_reg,
  output wire       auth_done,
  output wire       receiver_key_ready,
  output wire       repeater_key_list_ready
);

  ////////////////////////////////////////////////////////////////////////////
  // Write decode

  function wire_one;
    input [7:0] data;
    input integer pos;
    begin
      wire_one = data[pos];
    end
  endfunction

  wire       ctrl_wr;
  wire       rst_cmd;
  wire       cmd_ok;
  wire       policy_always;
  wire       cipher_on_eff;
  reg        cipher_on_reg;
  reg        cipher_on_next;
  reg        auth_enable_next;
  reg        key_ok_next;
  reg        key_rdy_seen_reg;
  reg        key_ok_pulse_reg;
  wire       key_rdy_rise;

  assign ctrl_wr = reg_wr_en && (reg_addr == `LPC_CTRL_ADDR);
  assign rst_cmd = ctrl_wr && wire_one(reg_wr_data, `LPC_BIT_ENG_RESET);
  // A reset command masks every other bit of the same write
  assign cmd_ok  = ctrl_wr && !rst_cmd;
  assign policy_always = (cipher_policy == `LPC_POLICY_ALWAYS);
  assign cipher_on_eff = policy_always | cipher_on_reg;
  assign key_rdy_rise  = receiver_key_ready && !key_rdy_seen_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Level state

  always @* begin
    auth_enable_next = auth_enable_reg;
    cipher_on_next   = cipher_on_reg;
    key_ok_next      = receiver_key_approved_reg;
    if (rst_cmd) begin
      auth_enable_next = 1'b0;
      key_ok_next      = 1'b0;
    end else begin
      if (key_rdy_rise) begin
        key_ok_next = 1'b0;
      end
      if (cmd_ok && wire_one(reg_wr_data, `LPC_BIT_KEY_OK)) begin
        key_ok_next = 1'b1;
      end
      if (cmd_ok && wire_one(reg_wr_data, `LPC_BIT_AUTH_START)) begin
        auth_enable_next = 1'b1;
      end
      // Disable beats start in the same write
      if (cmd_ok && wire_one(reg_wr_data, `LPC_BIT_AUTH_DIS)) begin
        auth_enable_next = 1'b0;
        key_ok_next      = 1'b0;
      end
      if (cmd_ok) begin
        cipher_on_next = wire_one(reg_wr_data, `LPC_BIT_CIPHER_ON);
      end
      // Cipher-off beats cipher-on in the same write
      if (cmd_ok && wire_one(reg_wr_data, `LPC_BIT_CIPHER_OFF)) begin
        cipher_on_next = 1'b0;
      end
    end
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      auth_enable_reg           <= 1'b0;
      cipher_on_reg             <= 1'b0;
      receiver_key_approved_reg <= 1'b0;
      key_rdy_seen_reg          <= 1'b0;
    end else begin
      auth_enable_reg           <= auth_enable_next;
      cipher_on_reg             <= cipher_on_next;
      receiver_key_approved_reg <= key_ok_next;
      key_rdy_seen_reg          <= receiver_key_ready;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command pulses, one cycle each, never stored

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      protect_engine_reset_reg       <= 1'b0;
      auth_restart_reg               <= 1'b0;
      auth_disable_pulse_reg         <= 1'b0;
      repeater_key_list_approved_reg <= 1'b0;
      cipher_off_pulse_reg           <= 1'b0;
      key_ok_pulse_reg               <= 1'b0;
    end else begin
      protect_engine_reset_reg <= rst_cmd;
      auth_restart_reg <= cmd_ok &&
        wire_one(reg_wr_data, `LPC_BIT_AUTH_START) &&
        !wire_one(reg_wr_data, `LPC_BIT_AUTH_DIS);
      auth_disable_pulse_reg <= cmd_ok &&
        wire_one(reg_wr_data, `LPC_BIT_AUTH_DIS);
      repeater_key_list_approved_reg <= cmd_ok &&
        wire_one(reg_wr_data, `LPC_BIT_LIST_OK);
      cipher_off_pulse_reg <= cmd_ok &&
        wire_one(reg_wr_data, `LPC_BIT_CIPHER_OFF);
      // Approval write clears key-ready once; a level would mask new rises
      key_ok_pulse_reg <= cmd_ok &&
        wire_one(reg_wr_data, `LPC_BIT_KEY_OK);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Video path selection

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      encrypt_video_reg <= 1'b0;
      blue_screen_reg   <= 1'b0;
    end else begin
      encrypt_video_reg <= cipher_on_eff && auth_done;
      // Blue screen hides protected video until authenticated
      blue_screen_reg   <= cipher_on_eff && !auth_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags

  lpc_status u_status (
    .sys_clk                     (sys_clk),
    .rstn                        (rstn),
    .key_ready_set               (key_ready_set),
    .list_ready_set              (list_ready_set),
    .auth_pass_set               (auth_pass_set),
    .auth_lost                   (auth_lost),
    .key_approve_pulse           (key_ok_pulse_reg),
    .list_approve_pulse          (repeater_key_list_approved_reg),
    .restart_pulse               (auth_restart_reg),
    .engine_stop_pulse           (protect_engine_reset_reg |
                                  auth_disable_pulse_reg),
    .auth_done_reg               (auth_done),
    .receiver_key_ready_reg      (receiver_key_ready),
    .repeater_key_list_ready_reg (repeater_key_list_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read port, one cycle latency, unmapped reads return zero

  reg [7:0] rd_next;

  always @* begin
    rd_next = 8'h00;
    if (reg_addr == `LPC_CTRL_ADDR) begin
      rd_next[`LPC_BIT_KEY_OK]     = receiver_key_approved_reg;
      rd_next[`LPC_BIT_CIPHER_ON]  = cipher_on_eff;
      rd_next[`LPC_BIT_AUTH_START] = auth_enable_reg;
    end else if (reg_addr == `LPC_STATUS_ADDR) begin
      rd_next[`LPC_STS_AUTH_DONE] = auth_done;
      rd_next[`LPC_STS_KEY_RDY]   = receiver_key_ready;
      rd_next[`LPC_STS_LIST_RDY]  = repeater_key_list_ready;
    end
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rd_data_reg  <= 8'h00;
      reg_rd_valid_reg <= 1'b0;
    end else begin
      reg_rd_valid_reg <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rd_data_reg <= rd_next;
      end
    end
  end

endmodule // lpc_ctrl

// >>> lpc_ctrl_sva.sv
`timescale 1ns/1ps
module lpc_ctrl_sva (
  input wire       sys_clk,
  input wire       rstn,
  input wire [7:0] reg_addr,
  input wire       reg_wr_en,
  input wire [7:0] reg_wr_data,
  input wire       reg_rd_en,
  input wire [1:0] cipher_policy,
  input wire [7:0] reg_rd_data_reg,
  input wire       protect_engine_reset_reg,
  input wire       auth_enable_reg,
  input wire       auth_restart_reg,
  input wire       auth_disable_pulse_reg,
  input wire       receiver_key_approved_reg,
  input wire       repeater_key_list_approved_reg,
  input wire       cipher_off_pulse_reg,
  input wire       encrypt_video_reg,
  input wire       blue_screen_reg,
  input wire       auth_done,
  input wire       receiver_key_ready
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Control writes only; other addresses must not act
  wire wr_c = reg_wr_en && (reg_addr == 8'hc3);
  wire rst_w = wr_c && reg_wr_data[7];
  chk_reset_pulse: assert property (rst_w |=> protect_engine_reset_reg
    ##1 !protect_engine_reset_reg) else $error("engine reset pulse wrong");
  chk_reset_wins: assert property (rst_w |=> !auth_enable_reg
    && !receiver_key_approved_reg) else $error("reset did not win");
  chk_start_auth: assert property (wr_c && reg_wr_data[1:0] == 2'b01
    && !reg_wr_data[7] |=> auth_enable_reg && auth_restart_reg)
    else $error("start write failed");
  chk_zero_write: assert property (wr_c && reg_wr_data == 8'h00
    |=> $stable(auth_enable_reg)) else $error("zero write acted");
  chk_disable_auth: assert property (wr_c && reg_wr_data[1]
    && !reg_wr_data[7] |=> auth_disable_pulse_reg && !auth_enable_reg)
    else $error("disable write failed");
  chk_cipher_off: assert property (wr_c && reg_wr_data[3]
    && !reg_wr_data[7] |=> cipher_off_pulse_reg ##1 !cipher_off_pulse_reg)
    else $error("cipher off pulse wrong");
  chk_list_pulse: assert property (wr_c && reg_wr_data[5]
    && !reg_wr_data[7] |=> repeater_key_list_approved_reg
    ##1 !repeater_key_list_approved_reg) else $error("list pulse wrong");
  chk_key_clear: assert property ($rose(receiver_key_ready)
    && !(wr_c && reg_wr_data[4]) |=> !receiver_key_approved_reg)
    else $error("key approval not cleared");
  chk_encrypt_auth: assert property (encrypt_video_reg
    |-> $past(auth_done)) else $error("encrypt without auth");
  chk_blue_auth: assert property (blue_screen_reg
    |-> !$past(auth_done)) else $error("blue while auth_done");
  chk_always_enc: assert property (cipher_policy == 2'b10 && auth_done
    |=> encrypt_video_reg) else $error("always policy not encrypting");
  chk_forced_read: assert property (reg_rd_en && reg_addr == 8'hc3
    && cipher_policy == 2'b10 |=> reg_rd_data_reg[2])
    else $error("cipher on not read as one");
endmodule // lpc_ctrl_sva
bind lpc_ctrl lpc_ctrl_sva u_sva (.sys_clk(sys_clk), .rstn(rstn),
  .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
  .reg_rd_en(reg_rd_en), .cipher_policy(cipher_policy),
  .reg_rd_data_reg(reg_rd_data_reg),
  .protect_engine_reset_reg(protect_engine_reset_reg),
  .auth_enable_reg(auth_enable_reg), .auth_restart_reg(auth_restart_reg),
  .auth_disable_pulse_reg(auth_disable_pulse_reg),
  .receiver_key_approved_reg(receiver_key_approved_reg),
  .repeater_key_list_approved_reg(repeater_key_list_approved_reg),
  .cipher_off_pulse_reg(cipher_off_pulse_reg),
  .encrypt_video_reg(encrypt_video_reg), .blue_screen_reg(blue_screen_reg),
  .auth_done(auth_done), .receiver_key_ready(receiver_key_ready));

// >>> tb.sv
`timescale 1ns/1ps
module tb;
  reg        sys_clk, rstn, wr_en, rd_en;
  reg  [7:0] addr, wdata;
  reg  [1:0] pol;
  reg  [3:0] evt;
  wire [7:0] rdata;
  wire       rvld, eng_rst, en, rs, dis, key_ok, lst_ok, coff, enc, blue;
  wire       done, key_rdy, lst_rdy;
  integer    err_count, checks_done;
  lpc_ctrl dut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(addr),
    .reg_wr_en(wr_en), .reg_wr_data(wdata), .reg_rd_en(rd_en),
    .cipher_policy(pol), .key_ready_set(evt[0]), .list_ready_set(evt[1]),
    .auth_pass_set(evt[2]), .auth_lost(evt[3]), .reg_rd_data_reg(rdata),
    .reg_rd_valid_reg(rvld), .protect_engine_reset_reg(eng_rst),
    .auth_enable_reg(en), .auth_restart_reg(rs),
    .auth_disable_pulse_reg(dis), .receiver_key_approved_reg(key_ok),
    .repeater_key_list_approved_reg(lst_ok), .cipher_off_pulse_reg(coff),
    .encrypt_video_reg(enc), .blue_screen_reg(blue), .auth_done(done),
    .receiver_key_ready(key_rdy), .repeater_key_list_ready(lst_rdy));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task wrap_up;
    begin
      if (err_count == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // Bus tasks leave a settle delay so pulses are sampled after the edge
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge sys_clk); addr <= a; wdata <= d; wr_en <= 1'b1;
      @(posedge sys_clk); wr_en <= 1'b0; #1;
    end
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    begin
      @(posedge sys_clk); addr <= a; rd_en <= 1'b1;
      @(posedge sys_clk); rd_en <= 1'b0; #1;
      chk(rvld, 8'h01);
      chk(rdata, exp);
    end
  endtask
  task ev(input [3:0] m);
    begin
      @(posedge sys_clk); evt <= m;
      @(posedge sys_clk); evt <= 4'h0; #1;
    end
  endtask
  task tick;
    begin @(posedge sys_clk); #1; end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_idle;
    begin
      rd(8'hc3, 8'h00);
      rd(8'hc4, 8'h00);
      rd(8'h10, 8'h00);
    end
  endtask
  task t_start;
    begin
      wr(8'hc3, 8'h01); chk(en, 8'h01); chk(rs, 8'h01);
      wr(8'hc3, 8'h00); chk(en, 8'h01);
      rd(8'hc3, 8'h01);
      ev(4'h4); chk(done, 8'h01);
      wr(8'hc3, 8'h01); chk(rs, 8'h01);
      tick; chk(done, 8'h00);
    end
  endtask
  task t_cipher;
    begin
      wr(8'hc3, 8'h04); tick; chk(blue, 8'h01); chk(enc, 8'h00);
      ev(4'h4); tick; chk(enc, 8'h01); chk(blue, 8'h00);
      wr(8'hc3, 8'h08); chk(coff, 8'h01);
      tick; chk(enc, 8'h00); chk(blue, 8'h00); chk(done, 8'h01);
      rd(8'hc3, 8'h01);
      @(posedge sys_clk); pol <= 2'b10;
      rd(8'hc3, 8'h05); chk(enc, 8'h01);
      @(posedge sys_clk); pol <= 2'b00;
    end
  endtask
  task t_keys;
    begin
      ev(4'h1); chk(key_rdy, 8'h01);
      wr(8'hc3, 8'h10); chk(key_ok, 8'h01);
      tick; chk(key_rdy, 8'h00);
      wr(8'hc3, 8'h00); chk(key_ok, 8'h01);
      ev(4'h1); chk(key_rdy, 8'h01);
      tick; chk(key_ok, 8'h00);
      ev(4'h2); chk(lst_rdy, 8'h01);
      wr(8'hc3, 8'h20); chk(lst_ok, 8'h01);
      tick; chk(lst_ok, 8'h00); chk(lst_rdy, 8'h00);
    end
  endtask
  task t_stop;
    begin
      wr(8'hc3, 8'h02); chk(dis, 8'h01); chk(en, 8'h00);
      rd(8'hc3, 8'h00);
      wr(8'hc3, 8'h10); wr(8'hc3, 8'h91); chk(eng_rst, 8'h01);
      chk(en, 8'h00); chk(key_ok, 8'h00);
      tick; chk(eng_rst, 8'h00);
      wr(8'hc2, 8'h01); chk(en, 8'h00);
      wr(8'hc3, 8'h01); ev(4'h4); ev(4'h8); chk(done, 8'h00);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    err_count = 0; checks_done = 0; rstn = 1'b0; wr_en = 1'b0;
    rd_en = 1'b0; addr = 8'h00; wdata = 8'h00; pol = 2'b00; evt = 4'h0;
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    t_idle; t_start; t_cipher; t_keys; t_stop;
    wrap_up;
  end
  // Hang guard: far beyond the expected run length
  initial begin
    #2000000;
    err_count = err_count + 1;
    wrap_up;
  end
endmodule // tb
